//--- rtl/slq_pkg.sv
// package for the scan list converter sequencer: host port map, entry layout, timing
// assumes a single 250 MHz clock shared by both ends
package slq_pkg;
  // host register map: one block of 16 byte offsets
  localparam int          SLQ_ADDR_W       = 4;
  localparam logic [3:0]  SLQ_OFS_CTRL     = 4'h2;    // control: mode, start, stop
  localparam logic [3:0]  SLQ_OFS_STATUS   = 4'h2;    // status on read
  localparam logic [3:0]  SLQ_OFS_SAMPLE   = 4'h0;    // last sample, read
  localparam logic [3:0]  SLQ_OFS_SCAN     = 4'h1;    // scan list byte port, write
  localparam logic [3:0]  SLQ_OFS_FLUSH    = 4'h4;    // scan list flush, write
  localparam logic [3:0]  SLQ_OFS_COR      = 4'he;    // configuration-option register
  localparam logic [3:0]  SLQ_OFS_AUX      = 4'hf;    // auxiliary control
  // control register fields
  localparam int          SLQ_CTRL_CONT    = 0;       // 1 continuous, 0 one-shot
  localparam int          SLQ_CTRL_START   = 1;       // software trigger, self clearing
  localparam int          SLQ_CTRL_STOP    = 2;       // stop conversions, self clearing
  localparam int          SLQ_CTRL_HIGAIN  = 3;       // high gain variant select
  localparam int          SLQ_CTRL_RES12   = 4;       // 12-bit converter variant
  localparam int          SLQ_AUX_PWRDN    = 2;       // power-down bit
  // scan entry fields
  localparam int          SLQ_E_FIRST      = 7;       // first-channel flag, low byte
  localparam int          SLQ_E_SSH        = 6;       // sync sample-hold, low byte
  localparam int          SLQ_E_DIFF       = 14;      // differential select
  localparam int          SLQ_E_GAIN_LO    = 12;      // gain bits 4..5 of high byte
  localparam int          SLQ_E_CHAN_LO    = 8;       // channel bits 0..2 of high byte
  // timing: one conversion every 10 us at 4 ns period
  localparam int          SLQ_CLK_PS       = 4000;
  localparam int          SLQ_CONV_NS      = 10000;
  localparam int          SLQ_CONV_CYC     = (SLQ_CONV_NS * 1000) / SLQ_CLK_PS;
  localparam int          SLQ_LIST_MAX     = 2048;
  localparam int          SLQ_LSB_ZERO     = 4;       // low bits forced zero on 12-bit
  localparam logic [15:0] SLQ_SAMPLE_RST   = 16'h0000;
  // host-side command codes
  typedef enum logic [2:0] {
    SLQ_CMD_NONE  = 3'h0,
    SLQ_CMD_WRITE = 3'h1,
    SLQ_CMD_READ  = 3'h2
  } slq_cmd_t;
endpackage

//--- rtl/slq_if.sv
// interface joining the host controller and the converter card
// assumes both ends share clk; read data stands one cycle after the read strobe
`timescale 1ns/1ps
interface slq_if;
  logic       clk;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  modport card (input clk, addr, wdata, wr, rd, output rdata);
  modport host (input clk, rdata, output addr, wdata, wr, rd);
endinterface

//--- rtl/slq_card.sv
// converter card end: host register block, power control and scan list sequencer
// assumes host accesses arrive on the shared clock; analog side is modelled by ports
//
// Notes on behaviour
// - samples left-justified two's complement, 12-bit low zeros
// - sixteen byte host register block decoded
// - at most one conversion per 10 us; a start right after a stop is not held off and converts the next cycle
// - analog supply off after reset
// - configuration-option write wakes the card
// - aux bit 2 powers down after wake
// - entry bit 14 selects differential input
// - differential channels 4-7 ground amplifier inputs
// - high byte bits 4-5 choose gain
// - gain applied per entry while advancing
// - high byte on-board, low byte external selection
// - list holds one to 2048 entries
// - entries independent, any channel any order
// - host flushes list before writing entries
// - host writes low then high byte pairs
// - low byte bit 6 drives sample-hold
// - host flags the first entry of each segment
// - one scan per trigger or pacer pulse
// - stop before next flagged entry, await trigger
// - no flagged entry means endless scanning
// - several flags split list into segments
// - lone later flag gives rotated scan
// - continuous: first scan immediate, rest paced
`timescale 1ns/1ps
module slq_card #(
  parameter int DEPTH    = slq_pkg::SLQ_LIST_MAX,
  parameter int CONV_CYC = slq_pkg::SLQ_CONV_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // host side
  slq_if.card              bus,
  // triggers from the trigger logic
  input  wire logic        ext_trig,
  input  wire logic        pacer_tick,
  // converter result
  input  wire logic [15:0] adc_raw,
  // analog front end controls
  output logic             full_power,
  output logic [2:0]       chan_sel,
  output logic [1:0]       gain_sel,
  output logic             gain_high,
  output logic             diff_sel,
  output logic             amp_gnd,
  output logic [5:0]       ext_sel,
  output logic             ssh,
  output logic             convert,
  output logic [15:0]      sample,
  output logic             sample_vld,
  output logic             busy
);
  import slq_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // refuse sizes the pointer and slot counter cannot serve
  if (DEPTH < 2 || DEPTH > SLQ_LIST_MAX || CONV_CYC < 2) begin : g_bad_param
    $error("slq_card: bad parameter");
  end

  typedef enum logic [2:0] {
    SLQ_IDLE = 3'b001,
    SLQ_CONV = 3'b010,
    SLQ_WAIT = 3'b100
  } slq_state_t;

  logic [15:0]   list_mem [DEPTH];
  logic [7:0]    low_ff;
  logic          half_ff;
  logic [AW:0]   count_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW-1:0] start_ff;
  logic          seen_ff;
  logic          fresh_ff;
  logic          woke_ff;
  logic          full_power_ff;
  logic [4:0]    ctrl_ff;
  logic          running_ff;
  logic          first_done_ff;
  slq_state_t    state_ff;
  logic [15:0]   cyc_ff;
  logic [15:0]   entry_ff;
  logic [15:0]   sample_ff;
  logic          vld_ff;
  logic [7:0]    rdata_ff;

  // byte decode helper
  function automatic logic hit(input logic [3:0] ofs);
    return bus.wr && bus.addr == ofs;
  endfunction

  wire logic sw_start = hit(SLQ_OFS_CTRL) && bus.wdata[SLQ_CTRL_START];
  wire logic sw_stop  = hit(SLQ_OFS_CTRL) && bus.wdata[SLQ_CTRL_STOP];
  wire logic cont     = ctrl_ff[SLQ_CTRL_CONT];
  wire logic trig     = sw_start || (running_ff && ext_trig);
  // one scan per trigger; paced scans only after the first
  wire logic go       = count_ff != '0 && full_power_ff &&
                        (trig || (running_ff && cont && first_done_ff && pacer_tick));
  wire logic [AW-1:0] nxt_rptr = (rptr_ff == AW'(count_ff - 1'b1)) ? '0 : rptr_ff + 1'b1;
  wire logic [15:0]   nxt_entry = list_mem[nxt_rptr];
  // a fresh list starts at its first flagged entry, otherwise where the last scan stopped
  wire logic [AW-1:0] start_ptr = fresh_ff ? start_ff : rptr_ff;

  // control register and run state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_ff       <= '0;
      running_ff    <= 1'b0;
      first_done_ff <= 1'b0;
    end else begin
      if (hit(SLQ_OFS_CTRL)) ctrl_ff <= bus.wdata[4:0];
      if (sw_stop) begin
        running_ff    <= 1'b0;
        first_done_ff <= 1'b0;
      end else if (sw_start) begin
        running_ff <= 1'b1;
      end
      if (go) first_done_ff <= 1'b1;
    end
  end

  // power mode: asleep from reset, woken by the configuration-option write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      full_power_ff <= 1'b0;
      woke_ff       <= 1'b0;
    end else if (hit(SLQ_OFS_COR)) begin
      full_power_ff <= 1'b1;
      woke_ff       <= 1'b1;
    end else if (hit(SLQ_OFS_AUX) && bus.wdata[SLQ_AUX_PWRDN] && woke_ff) begin
      full_power_ff <= 1'b0;
    end
  end

  // scan list fill: low byte then high byte form one entry
  always_ff @(posedge clk) begin
    if (!reset_n || hit(SLQ_OFS_FLUSH)) begin
      half_ff  <= 1'b0;
      count_ff <= '0;
      low_ff   <= '0;
      start_ff <= '0;
      seen_ff  <= 1'b0;
    end else if (hit(SLQ_OFS_SCAN)) begin
      half_ff <= !half_ff;
      if (!half_ff) begin
        low_ff <= bus.wdata;
      end else if (count_ff < (AW+1)'(DEPTH)) begin
        count_ff <= count_ff + 1'b1;
        // remember where the first flagged entry sits
        if (low_ff[SLQ_E_FIRST] && !seen_ff) begin
          start_ff <= count_ff[AW-1:0];
          seen_ff  <= 1'b1;
        end
      end
    end
  end

  // list storage, no reset
  always_ff @(posedge clk) begin
    if (hit(SLQ_OFS_SCAN) && half_ff && count_ff < (AW+1)'(DEPTH)) begin
      list_mem[count_ff[AW-1:0]] <= {bus.wdata, low_ff};
    end
  end

  // sequencer: one conversion per slot, stop before the next flagged entry
  always_ff @(posedge clk) begin
    if (!reset_n || hit(SLQ_OFS_FLUSH)) begin
      state_ff <= SLQ_IDLE;
      rptr_ff  <= '0;
      cyc_ff   <= '0;
      entry_ff <= '0;
      fresh_ff <= 1'b1;
    end else if (sw_stop || !full_power_ff) begin
      state_ff <= SLQ_IDLE;
    end else begin
      case (state_ff)
        SLQ_IDLE: begin
          if (go) begin
            entry_ff <= list_mem[start_ptr];
            rptr_ff  <= start_ptr;
            fresh_ff <= 1'b0;
            cyc_ff   <= '0;
            state_ff <= SLQ_CONV;
          end
        end
        SLQ_CONV: begin
          if (cyc_ff == 16'(CONV_CYC - 1)) begin
            cyc_ff  <= '0;
            rptr_ff <= nxt_rptr;
            entry_ff <= nxt_entry;
            // flagged next entry ends the segment; none flagged never ends
            state_ff <= nxt_entry[SLQ_E_FIRST] ? SLQ_IDLE : SLQ_CONV;
          end else begin
            cyc_ff <= cyc_ff + 1'b1;
          end
        end
        default: state_ff <= SLQ_IDLE;
      endcase
    end
  end

  // sample capture at the end of each conversion slot
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sample_ff <= SLQ_SAMPLE_RST;
      vld_ff    <= 1'b0;
    end else begin
      vld_ff <= state_ff == SLQ_CONV && cyc_ff == 16'(CONV_CYC - 1);
      if (state_ff == SLQ_CONV && cyc_ff == 16'(CONV_CYC - 1)) begin
        sample_ff <= ctrl_ff[SLQ_CTRL_RES12] ? {adc_raw[15:SLQ_LSB_ZERO], 4'h0} : adc_raw;
      end
    end
  end

  // host read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_ff <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        SLQ_OFS_SAMPLE: rdata_ff <= sample_ff[15:8];
        SLQ_OFS_STATUS: rdata_ff <= {4'h0, running_ff, state_ff == SLQ_CONV, woke_ff, full_power_ff};
        SLQ_OFS_SCAN:   rdata_ff <= sample_ff[7:0];
        default:        rdata_ff <= 8'h00;
      endcase
    end
  end

  // front end drive from the current entry, high gain select from the control register
  assign bus.rdata  = rdata_ff;
  assign full_power = full_power_ff;
  assign chan_sel   = entry_ff[SLQ_E_CHAN_LO +: 3];
  assign gain_sel   = entry_ff[SLQ_E_GAIN_LO +: 2];
  assign gain_high  = ctrl_ff[SLQ_CTRL_HIGAIN];
  assign diff_sel   = entry_ff[SLQ_E_DIFF];
  assign amp_gnd    = entry_ff[SLQ_E_DIFF] && entry_ff[SLQ_E_CHAN_LO + 2];
  assign ext_sel    = entry_ff[5:0];
  assign ssh        = entry_ff[SLQ_E_SSH] && state_ff == SLQ_CONV;
  assign convert    = state_ff == SLQ_CONV && cyc_ff == '0;
  assign sample     = sample_ff;
  assign sample_vld = vld_ff;
  assign busy       = state_ff != SLQ_IDLE;
endmodule

//--- rtl/slq_host.sv
// host controller end: forwards software register accesses onto the card port
// assumes software uses the plain strobe port on the shared clock
`timescale 1ns/1ps
module slq_host (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // software command port
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic [7:0]      sw_rdata,
  // card side
  slq_if.host             bus
);
  import slq_pkg::*;

  logic [3:0] addr_ff;
  logic [7:0] wdata_ff;
  logic       wr_ff;
  logic       rd_ff;
  logic       rd_wait_ff;
  logic [7:0] rdata_ff;

  // register the command onto the card port; flush, byte pairing and flag placement are software's
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_ff  <= '0;
      wdata_ff <= '0;
      wr_ff    <= 1'b0;
      rd_ff    <= 1'b0;
    end else begin
      addr_ff  <= sw_addr;
      wdata_ff <= sw_wdata;
      wr_ff    <= sw_wr;  // wake write to the option register passes here
      rd_ff    <= sw_rd && !sw_wr;
    end
  end

  // return card read data one cycle after it appears
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_wait_ff <= 1'b0;
      rdata_ff   <= '0;
    end else begin
      rd_wait_ff <= rd_ff;
      if (rd_wait_ff) rdata_ff <= bus.rdata;
    end
  end

  assign bus.addr  = addr_ff;
  assign bus.wdata = wdata_ff;
  assign bus.wr    = wr_ff;
  assign bus.rd    = rd_ff;
  assign sw_rdata  = rdata_ff;
endmodule

//--- dv/slq_asserts.sv
// checker for the host-card link and the card's front end outputs
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module slq_asserts #(
  parameter int CONV_CYC = 8
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // link signals
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // card outputs
  input wire logic       full_power,
  input wire logic [2:0] chan_sel,
  input wire logic       diff_sel,
  input wire logic       amp_gnd,
  input wire logic       convert,
  input wire logic       sample_vld,
  input wire logic       busy
);
  import slq_pkg::*;
  localparam int VLD_MAX = CONV_CYC + 2;
  logic [15:0] gap_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // cycles since the last conversion start, saturating
  always_ff @(posedge clk) begin
    if (!reset_n) gap_ff <= 16'hffff;
    else if (convert) gap_ff <= 16'h0000;
    else if (gap_ff != 16'hffff) gap_ff <= gap_ff + 16'h0001;
  end
  property p_rst;
    disable iff (1'b0) !reset_n |=> !full_power;
  endproperty
  a_rst: assert property (p_rst) else $error("analog supply on after reset");
  property p_wake;
    $rose(full_power) |-> $past(wr) && $past(addr) == SLQ_OFS_COR;
  endproperty
  a_wake: assert property (p_wake) else $error("woke without option write");
  property p_pwrdn;
    $fell(full_power) |-> $past(wr) && $past(addr) == SLQ_OFS_AUX && ($past(wdata) & 8'h04) != 8'h00;
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("power down without aux write");
  property p_excl;
    !(wr && rd);
  endproperty
  a_excl: assert property (p_excl) else $error("both strobes at once");
  property p_stat;
    rd && addr == SLQ_OFS_STATUS |=> rdata[0] == $past(full_power);
  endproperty
  a_stat: assert property (p_stat) else $error("status power bit wrong");
  property p_gnd;
    convert |-> amp_gnd == (diff_sel && chan_sel[2]);
  endproperty
  a_gnd: assert property (p_gnd) else $error("amplifier ground select wrong");
  property p_rate;
    convert |-> gap_ff >= 16'(CONV_CYC - 1);
  endproperty
  a_rate: assert property (p_rate) else $error("conversions too close");
  property p_vld;
    convert |-> ##[1:VLD_MAX] (sample_vld || !busy);
  endproperty
  a_vld: assert property (p_vld) else $error("no sample after conversion");
endmodule

//--- dv/tb_top.sv
// bench: software port drives the host end, which drives the card end
// assumes slq_pkg offsets and a shortened conversion slot
`timescale 1ns/1ps
module tb_top;
  import slq_pkg::*;
  localparam int CC = 8;
  logic        clk, reset_n, sw_wr, sw_rd, ext_trig, pacer_tick;
  logic [3:0]  sw_addr;
  logic [2:0]  chan_sel;
  logic [7:0]  sw_wdata, sw_rdata, d;
  logic [15:0] adc_raw, sample;
  logic [1:0]  gain_sel;
  logic [5:0]  ext_sel;
  logic        full_power, gain_high, diff_sel, amp_gnd, ssh, convert, sample_vld, busy;
  logic [15:0] ent [3] = '{16'h6503, 16'h314a, 16'h5215};
  int          err_count = 0, n_compared = 0, cyc = 0;
  slq_if link_if ();
  assign link_if.clk = clk;
  slq_host slq_host_inst (.clk(clk), .reset_n(reset_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(link_if));
  slq_card #(.DEPTH(16), .CONV_CYC(CC)) slq_card_inst (.clk(clk), .reset_n(reset_n), .bus(link_if),
    .ext_trig(ext_trig), .pacer_tick(pacer_tick), .adc_raw(adc_raw), .full_power(full_power),
    .chan_sel(chan_sel[2:0]), .gain_sel(gain_sel), .gain_high(gain_high), .diff_sel(diff_sel), .amp_gnd(amp_gnd),
    .ext_sel(ext_sel), .ssh(ssh), .convert(convert), .sample(sample), .sample_vld(sample_vld), .busy(busy));
  slq_asserts #(.CONV_CYC(CC)) chk_inst (.clk(clk), .reset_n(reset_n), .addr(link_if.addr),
    .wdata(link_if.wdata), .wr(link_if.wr), .rd(link_if.rd), .rdata(link_if.rdata), .full_power(full_power),
    .chan_sel(chan_sel[2:0]), .diff_sel(diff_sel), .amp_gnd(amp_gnd), .convert(convert),
    .sample_vld(sample_vld), .busy(busy));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= v;
    sw_wr    <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  // read data stands two edges after the strobe is taken; the task samples it after three
  task automatic sw_read(input logic [3:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    repeat (3) @(posedge clk);
    #1 d = sw_rdata;
  endtask
  task automatic load(input logic [2:0] fm);
    sw_write(SLQ_OFS_FLUSH, 8'h00);
    for (int i = 0; i < 3; i++) begin
      sw_write(SLQ_OFS_SCAN, {fm[i], ent[i][6:0]});
      sw_write(SLQ_OFS_SCAN, ent[i][15:8]);
    end
  endtask
  // watch one scan: front end fields per entry, sample value, entry count
  task automatic scan(input int first, input int n, input logic [15:0] exp);
    int          idx;
    int          cnt;
    logic [15:0] e;
    idx = first;
    cnt = 0;
    repeat (n * CC + 40) begin
      #1;
      if (convert === 1'b1) begin
        e = ent[idx];
        chk({2'b00, ssh, ext_sel, amp_gnd, diff_sel, gain_sel, chan_sel[2:0]},
            {2'b00, e[6], e[5:0], e[14] & e[10], e[14], e[13:12], e[10:8]});
        idx = (idx + 1) % 3;
        cnt++;
      end
      if (sample_vld === 1'b1) chk(sample, exp);
      @(posedge clk);
    end
    chk(16'(cnt), 16'(n));
  endtask
  task automatic t_power();
    chk({15'h0, full_power}, 16'h0000);
    sw_write(SLQ_OFS_COR, 8'h01);
    repeat (3) @(posedge clk);
    chk({15'h0, full_power}, 16'h0001);
    sw_read(SLQ_OFS_STATUS);
    chk({8'h00, d & 8'h01}, 16'h0001);
    sw_read(4'h7);
    chk({8'h00, d}, 16'h0000);
    sw_write(SLQ_OFS_AUX, 8'h04);
    repeat (3) @(posedge clk);
    chk({15'h0, full_power}, 16'h0000);
    sw_write(SLQ_OFS_COR, 8'h01);
    repeat (3) @(posedge clk);
    chk({15'h0, full_power}, 16'h0001);
  endtask
  // one-shot, segments, rotated start, free run, continuous
  task automatic t_scans();
    load(3'b001);
    sw_write(SLQ_OFS_CTRL, 8'h02);
    scan(0, 3, 16'h1235);
    sw_write(SLQ_OFS_CTRL, 8'h1a);
    scan(0, 3, 16'h1230);
    chk({15'h0, gain_high}, 16'h0001);
    sw_read(4'h1);
    chk({8'h00, d}, 16'h0030);
    load(3'b101);
    sw_write(SLQ_OFS_CTRL, 8'h02);
    scan(0, 2, 16'h1235);
    sw_write(SLQ_OFS_CTRL, 8'h02);
    scan(2, 1, 16'h1235);
    load(3'b010);
    sw_write(SLQ_OFS_CTRL, 8'h02);
    scan(1, 3, 16'h1235);
    load(3'b000);
    sw_write(SLQ_OFS_CTRL, 8'h02);
    repeat (120) @(posedge clk);
    chk({15'h0, busy}, 16'h0001);
    sw_write(SLQ_OFS_CTRL, 8'h04);
    repeat (20) @(posedge clk);
    load(3'b001);
    sw_write(SLQ_OFS_CTRL, 8'h03);
    scan(0, 3, 16'h1235);
    @(posedge clk);
    pacer_tick <= 1'b1;
    @(posedge clk);
    pacer_tick <= 1'b0;
    scan(0, 3, 16'h1235);
    // external trigger starts one more scan while running
    @(posedge clk);
    ext_trig <= 1'b1;
    @(posedge clk);
    ext_trig <= 1'b0;
    scan(0, 3, 16'h1235);
  endtask
  initial begin
    reset_n    = 1'b0;
    sw_wr      = 1'b0;
    sw_rd      = 1'b0;
    sw_addr    = 4'h0;
    sw_wdata   = 8'h00;
    ext_trig   = 1'b0;
    pacer_tick = 1'b0;
    adc_raw    = 16'h1235;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_power();
    t_scans();
    report_and_stop();
  end
endmodule
